//--- dv/pag_pins_model.sv
`timescale 1ns/1ps
module pag_pins_model (
  // Clock
  input  wire       clk,
  // Device side
  input  wire [4:0] pinOut,
  input  wire [4:0] pinOe,
  input  wire [4:0] pullupOn,
  // Board side
  input  wire [4:0] extDrive,
  input  wire [4:0] extLevel,
  output wire [4:0] pinIn
);
  reg [4:0] floatReg = 5'h0a;
  // Undriven pin without pull-up wanders
  always @(posedge clk)
    floatReg <= ~floatReg;
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive & extLevel)
               | (~pinOe & ~extDrive & (pullupOn | floatReg));
endmodule

//--- dv/pag_port_a_sva.sv
`timescale 1ns/1ps
module pag_port_a_sva (
  // Clock and resets
  input wire       clk,
  input wire       resetn,
  input wire       softResetn,
  // Watched signals
  input wire [4:0] pinOe,
  input wire [4:0] pullupOn,
  input wire [4:0] portRdata,
  input wire [4:0] dirRdata,
  input wire [4:0] pullupRdata,
  input wire       analogSelectPin4,
  input wire       pullupDisableAll,
  input wire       flagClear,
  input wire       changeIntFlag,
  input wire       changeWake,
  input wire       changeIntEnable,
  input wire       usbFunctionOn,
  input wire       oscOnPins45
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_wake_gated: assert property (changeWake == (changeIntFlag && changeIntEnable)) else $error("wake gate");
  a_drive_dir: assert property (!oscOnPins45 |-> pinOe == {~dirRdata[4:3], 3'h0}) else $error("oe");
  a_pullup_gate: assert property (!oscOnPins45 |-> pullupOn == (pullupRdata & ~pinOe & {5{!pullupDisableAll}}))
    else $error("pullup");
  a_osc_zero: assert property (oscOnPins45 |-> !dirRdata && !portRdata[4:3] && !pinOe) else $error("osc");
  a_usb_blind: assert property (usbFunctionOn |-> portRdata[1:0] == 2'h0) else $error("usb");
  a_flag_holds: assert property (changeIntFlag && !flagClear && softResetn |=> changeIntFlag) else $error("flag");
  a_por_values: assert property ($rose(resetn) |-> !pullupRdata && analogSelectPin4 && dirRdata[4:3] == 2'h3)
    else $error("por");
  a_analog_zero: assert property (analogSelectPin4 |-> !portRdata[3]) else $error("analog");
  cover property ($rose(changeIntFlag));
  cover property (changeWake);
  cover property (flagClear && changeIntFlag);
endmodule
bind pag_port_a pag_port_a_sva pag_port_a_sva_inst (.*);

//--- dv/pag_port_a_tb.sv
`timescale 1ns/1ps
module pag_port_a_tb;
  reg        clk = 0;
  reg        resetn = 0;
  reg        softResetn = 1;
  reg  [7:0] stb = 0;
  reg  [4:0] d = 0;
  reg  [4:0] extDrive = 5'h1f;
  reg  [4:0] extLevel = 0;
  reg  [5:0] cfg = 0;
  reg  [4:0] pu = 0;
  integer    seed = 39242;
  integer    n_fail = 0;
  integer    n_tests = 0;
  integer    i;
  wire [4:0] pinIn, pinOut, pinOe, pullupOn, portRdata, latchRdata, dirRdata, chgEnRdata, pullupRdata;
  wire       analogSelectPin4, changeIntFlag, changeWake;
  always #50 clk = ~clk;
  pag_port_a pag_port_a_inst (.clk(clk), .resetn(resetn), .softResetn(softResetn), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn), .portRead(stb[0]), .portWrite(stb[1]),
    .fileToFileMove(cfg[0]), .portWdata(d), .portRdata(portRdata), .latchWrite(stb[2]), .latchWdata(d),
    .latchRdata(latchRdata), .dirWrite(stb[3]), .dirWdata(d), .dirRdata(dirRdata), .chgEnWrite(stb[4]),
    .chgEnWdata(d), .chgEnRdata(chgEnRdata), .pullupWrite(stb[5]), .pullupWdata(d), .pullupRdata(pullupRdata),
    .analogWrite(stb[6]), .analogWdata(d[0]), .analogSelectPin4(analogSelectPin4), .changeIntEnable(cfg[1]),
    .pullupDisableAll(cfg[2]), .flagClear(stb[7]), .changeIntFlag(changeIntFlag), .changeWake(changeWake),
    .usbFunctionOn(cfg[3]), .masterClearSelect(cfg[4]), .oscOnPins45(cfg[5]));
  pag_pins_model pag_pins_model_inst (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn),
    .extDrive(extDrive), .extLevel(extLevel), .pinIn(pinIn));
  ////////////////////////////////////////////////////////////////
  function [4:0] exPins(input [4:0] v);
    exPins = v & 5'h18;
  endfunction
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task op(input [7:0] s, input [4:0] v);
    begin
      stb = s;
      d = v;
      tick(2);
      stb = 8'h00;
    end
  endtask
  task chk(input [8*6-1:0] nm, input [4:0] e, input [4:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        n_fail = n_fail + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #2000000;
    n_fail = n_fail + 1;
    wrap_up;
  end
  initial
  begin
    tick(5);
    resetn = 1;
    chk("dir", 5'h18, dirRdata);
    chk("analog", 5'h01, {4'h0, analogSelectPin4});
    $display("test reset done");
    op(8'h40, 5'h00);
    op(8'h08, 5'h00);
    for (i = 0; i < 12; i = i + 1)
    begin
      cfg[2] = $random(seed);
      pu = $random(seed);
      op(8'h20, pu);
      op(i[0] ? 8'h02 : 8'h04, $random(seed));
      tick(2);
      chk("drive", exPins(d), portRdata & 5'h18);
      chk("pinout", exPins(d), pinOut);
      chk("purd", pu, pullupRdata);
      chk("pullup", cfg[2] ? 5'h00 : (pu & 5'h07), pullupOn);
      chk("latch", exPins(d), latchRdata);
    end
    $display("test drive done");
    op(8'h08, 5'h1f);
    op(8'h10, 5'h1f);
    chk("chgen", 5'h1f, chgEnRdata);
    cfg[1] = 1;
    tick(3);
    op(8'h01, 5'h00);
    op(8'h80, 5'h00);
    chk("idle", 5'h00, {4'h0, changeIntFlag});
    extLevel = 5'h10;
    tick(4);
    chk("flag", 5'h01, {4'h0, changeIntFlag});
    chk("wake", 5'h01, {4'h0, changeWake});
    op(8'h80, 5'h00);
    chk("refuse", 5'h01, {4'h0, changeIntFlag});
    cfg[0] = 1;
    op(8'h01, 5'h00);
    cfg[0] = 0;
    op(8'h80, 5'h00);
    chk("move", 5'h01, {4'h0, changeIntFlag});
    op(8'h01, 5'h00);
    op(8'h80, 5'h00);
    chk("clear", 5'h00, {4'h0, changeIntFlag});
    extLevel = 5'h00;
    tick(4);
    softResetn = 0;
    tick(1);
    softResetn = 1;
    tick(4);
    chk("soft", 5'h01, {4'h0, changeIntFlag});
    op(8'h01, 5'h00);
    op(8'h80, 5'h00);
    op(8'h08, 5'h00);
    op(8'h04, 5'h10);
    tick(4);
    chk("outpin", 5'h00, {4'h0, changeIntFlag});
    $display("test change done");
    extLevel = 5'h1f;
    tick(3);
    chk("pins", 5'h17, portRdata);
    cfg[5] = 1;
    cfg[4] = 1;
    cfg[3] = 1;
    tick(1);
    chk("osc", 5'h00, dirRdata);
    chk("cfgpin", 5'h00, portRdata);
    cfg[5] = 0;
    cfg[4] = 0;
    cfg[3] = 0;
    $display("test config done");
    wrap_up;
  end
endmodule

//--- verilog/pag_defines.vh
`ifndef PAG_DEFINES_VH
`define PAG_DEFINES_VH

// Port width and pin positions
`define PAG_WIDTH        5
`define PAG_PIN0         0
`define PAG_PIN1         1
`define PAG_PIN3         2
`define PAG_PIN4         3
`define PAG_PIN5         4

// Reset values
`define PAG_DIR_RST      2'h3
`define PAG_LATCH_RST    2'h0
`define PAG_CHGEN_RST    5'h00
`define PAG_PULLUP_RST   5'h00
`define PAG_ANALOG_RST   1'h1
`define PAG_SNAP_RST     5'h00

// Synchroniser depth
`define PAG_SYNC_STAGES  2

`endif

//--- verilog/pag_port_a.v
// Functional notes
// - Five pins; 5,4 bidirectional, others input
// - Direction 1 input, 0 drives latch
// - Port read gives pins, write sets latch
// - Latch register readable and writable
// - Per-pin change enable bits
// - Global enable gates change interrupt
// - Output pins excluded from change compare
// - Mismatches against snapshot ORed into flag
// - Change interrupt wakes from sleep, idle
// - Port access recaptures snapshot, except move
// - Mismatch keeps setting flag
// - Snapshot survives master-clear and brown-out
// - Change at read instant still sets flag
// - USB disables change on pins 0,1
// - Pins 1,0 need both enables, no USB
// - Pull-up needs enable and no global disable
// - Pull-up off on output pins
// - Pull-ups disabled after power-on reset
// - Analog select on pin 4, set at reset
// - Pins 0,1 inputs only; USB owns direction
// - Pin 3 input when master clear off
// - Oscillator pins 4,5 read zero
`timescale 1ns/1ps
`include "pag_defines.vh"

module pag_port_a #(
  parameter WIDTH = `PAG_WIDTH
) (
  // Clock and resets
  input  wire             clk,
  input  wire             resetn,
  input  wire             softResetn,
  // Pins
  input  wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] pinOut,
  output wire [WIDTH-1:0] pinOe,
  output wire [WIDTH-1:0] pullupOn,
  // Port pins register access
  input  wire             portRead,
  input  wire             portWrite,
  input  wire             fileToFileMove,
  input  wire [WIDTH-1:0] portWdata,
  output wire [WIDTH-1:0] portRdata,
  // Output latch register access
  input  wire             latchWrite,
  input  wire [WIDTH-1:0] latchWdata,
  output wire [WIDTH-1:0] latchRdata,
  // Direction register access
  input  wire             dirWrite,
  input  wire [WIDTH-1:0] dirWdata,
  output wire [WIDTH-1:0] dirRdata,
  // Change enable register access
  input  wire             chgEnWrite,
  input  wire [WIDTH-1:0] chgEnWdata,
  output wire [WIDTH-1:0] chgEnRdata,
  // Pull-up enable register access
  input  wire             pullupWrite,
  input  wire [WIDTH-1:0] pullupWdata,
  output wire [WIDTH-1:0] pullupRdata,
  // Analog select
  input  wire             analogWrite,
  input  wire             analogWdata,
  output wire             analogSelectPin4,
  // Interrupt control and global pull-up disable
  input  wire             changeIntEnable,
  input  wire             pullupDisableAll,
  input  wire             flagClear,
  output wire             changeIntFlag,
  output wire             changeWake,
  // Configuration
  input  wire             usbFunctionOn,
  input  wire             masterClearSelect,
  input  wire             oscOnPins45
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg  [1:0]       dir_reg;
  reg  [1:0]       latch_reg;
  reg  [WIDTH-1:0] chgEn_reg;
  reg  [WIDTH-1:0] pullup_reg;
  reg              analog_reg;
  reg  [WIDTH-1:0] snap_reg;
  reg              flag_reg;
  wire [WIDTH-1:0] pinSync;
  wire             portAccess;
  wire             mismatch;
  wire [WIDTH-1:0] digMask;
  wire [WIDTH-1:0] inputMask;
  wire [WIDTH-1:0] pinLevel;
  wire [WIDTH-1:0] dirFull;
  wire             usbPinsOk;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser
  pag_sync #(
    .WIDTH  (WIDTH),
    .STAGES (`PAG_SYNC_STAGES)
  ) u_sync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (pinIn),
    .syncOut (pinSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin qualification
  assign usbPinsOk = chgEn_reg[`PAG_PIN1] & chgEn_reg[`PAG_PIN0] & ~usbFunctionOn;

  // Digital availability per pin
  assign digMask[`PAG_PIN0] = usbPinsOk;
  assign digMask[`PAG_PIN1] = usbPinsOk;
  assign digMask[`PAG_PIN3] = ~masterClearSelect;
  assign digMask[`PAG_PIN4] = ~oscOnPins45 & ~analog_reg;
  assign digMask[`PAG_PIN5] = ~oscOnPins45;

  // Direction of every pin, 1 is input
  assign dirFull = {dir_reg, 3'h7};

  assign pinLevel = pinSync & digMask;
  assign inputMask = dirFull;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  assign pinOe = oscOnPins45 ? {WIDTH{1'b0}} : {~dir_reg, 3'h0};
  assign pinOut = {latch_reg & ~dir_reg & {2{~oscOnPins45}}, 3'h0};

  // Pull-ups
  assign pullupOn = pullup_reg & dirFull & {WIDTH{~pullupDisableAll}};

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  assign portRdata   = pinLevel;
  assign latchRdata  = oscOnPins45 ? {WIDTH{1'b0}} : {latch_reg, 3'h0};
  assign dirRdata    = oscOnPins45 ? {WIDTH{1'b0}} : {dir_reg, 3'h0};
  assign chgEnRdata  = chgEn_reg;
  assign pullupRdata = pullup_reg;
  assign analogSelectPin4 = analog_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, power-on reset only
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dir_reg    <= `PAG_DIR_RST;
      latch_reg  <= `PAG_LATCH_RST;
      chgEn_reg  <= `PAG_CHGEN_RST;
      pullup_reg <= `PAG_PULLUP_RST;
      analog_reg <= `PAG_ANALOG_RST;
    end
    else
    begin
      if (dirWrite)
        dir_reg <= dirWdata[WIDTH-1:3];
      if (latchWrite)
        latch_reg <= latchWdata[WIDTH-1:3];
      else if (portWrite)
        latch_reg <= portWdata[WIDTH-1:3];
      if (chgEnWrite)
        chgEn_reg <= chgEnWdata;
      if (pullupWrite)
        pullup_reg <= pullupWdata;
      if (analogWrite)
        analog_reg <= analogWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change detection
  assign portAccess = (portRead | portWrite) & ~fileToFileMove;

  // Enabled inputs; USB pins masked when USB runs
  wire [WIDTH-1:0] cmpMask = chgEn_reg & inputMask &
                             {2'h3, 1'b1, {2{~usbFunctionOn}}};

  assign mismatch = |((pinLevel ^ snap_reg) & cmpMask);

  // Snapshot cleared only on power-on reset
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      snap_reg <= `PAG_SNAP_RST;
    else if (portAccess)
      snap_reg <= pinLevel;
  end

  // Flag cleared by any reset, set wins over clear
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flag_reg <= 1'b0;
    else if (!softResetn)
      flag_reg <= 1'b0;
    else if (mismatch)
      flag_reg <= 1'b1;
    else if (flagClear)
      flag_reg <= 1'b0;
  end

  assign changeIntFlag = flag_reg;
  assign changeWake = flag_reg & changeIntEnable;

endmodule

//--- verilog/pag_sync.v
`timescale 1ns/1ps
`include "pag_defines.vh"

module pag_sync #(
  parameter WIDTH  = `PAG_WIDTH,
  parameter STAGES = `PAG_SYNC_STAGES
) (
  // Clock and reset
  input  wire             clk,
  input  wire             resetn,
  // Data
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH*STAGES-1:0] chain_reg;

  // Shift chain, only last stage read outside
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      chain_reg <= {(WIDTH*STAGES){1'b0}};
    else
      chain_reg <= {chain_reg[WIDTH*(STAGES-1)-1:0], asyncIn};
  end

  assign syncOut = chain_reg[WIDTH*STAGES-1:WIDTH*(STAGES-1)];

endmodule
